// ### hcifc_regs.svh
// timing, baud and field constants for the hci serial port
// Functional notes
// - four pins: receive data in, transmit data out, clear-to-send in, ready-to-send out
// - hci traffic framed as h4 or h5 transport
// - after reset the port runs at 115.2 kilobaud until reconfigured
// - bit rates from 115.2 to 3000 kilobaud selectable
// - generated bit rate within plus or minus three percent of nominal
// - clear-to-send high: finish current byte, start no new one
// - clear-to-send sampled only before each byte; resume when low
// - packets at most 256 bytes, 1024 for asynchronous connection data
// - internal reset releases 2 to 8 ms after both supplies are up
// - power ready enables manager, then radio, then serial port init
// - commands ignored during 1 to 10 ms not-ready interval
`ifndef HCIFC_REGS_SVH
`define HCIFC_REGS_SVH
`define HCIFC_CLK_HZ 250000000
`define HCIFC_CLK_MHZ 250
`define HCIFC_T_POR_US 2000
`define HCIFC_T_NRDY_US 2000
`define HCIFC_BAUD_DEFAULT 3'h0
`define HCIFC_BIT_START 4'h0
`define HCIFC_BIT_STOP 4'h9
`define HCIFC_LEN_CMD 11'h100
`define HCIFC_LEN_ACL 11'h400
`define HCIFC_H5_DELIM 8'hc0
`endif

// ### hcifc_pkg.sv
// types shared by the hci serial port
package hcifc_pkg;
  // power-up sequence states
  typedef enum logic [2:0] {
    PWR_OFF, PWR_POR, PWR_PM, PWR_RADIO, PWR_NRDY, PWR_RDY
  } hcifc_pwr_t;
  // one byte offered for transmission
  typedef struct packed {
    logic last;
    logic acl;
    logic [7:0] data;
  } hcifc_tx_t;
  // one received byte
  typedef struct packed {
    logic frame_err;
    logic [7:0] data;
  } hcifc_rx_t;
endpackage : hcifc_pkg

// ### hcifc_top.sv
// hci serial port with cts pacing and power-up readiness sequence
`timescale 1ns/10ps
`include "hcifc_regs.svh"
module hcifc_top #(
  parameter int T_POR_CYC = `HCIFC_T_POR_US * `HCIFC_CLK_MHZ,
  parameter int T_NRDY_CYC = `HCIFC_T_NRDY_US * `HCIFC_CLK_MHZ
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // supply detection pins
  input wire logic main_supply_ok,
  input wire logic core_supply_on,
  // configuration
  input wire logic [2:0] baud_sel,
  input wire logic hw_flow_en,
  input wire logic h5_mode,
  // serial pins
  input wire logic uart_rxd,
  input wire logic uart_cts,
  output logic uart_txd,
  output logic uart_rts_n,
  // power-up status
  output logic pm_en,
  output logic radio_en,
  output logic uart_rdy,
  // transmit byte stream
  input wire logic tx_valid,
  input wire hcifc_pkg::hcifc_tx_t tx_req,
  output logic tx_ready,
  output logic pkt_len_err,
  // receive byte stream
  output logic rx_valid,
  output hcifc_pkg::hcifc_rx_t rx_byte
);
  import hcifc_pkg::*;

  // rounded divisor keeps every rate well inside three percent
  function automatic logic [15:0] baud_div(input logic [2:0] sel);
    int rate;
    rate = 115200;
    case (sel)
      3'h0: rate = 115200;
      3'h1: rate = 230400;
      3'h2: rate = 460800;
      3'h3: rate = 921600;
      3'h4: rate = 1500000;
      3'h5: rate = 2000000;
      3'h6: rate = 2500000;
      default: rate = 3000000;
    endcase
    return 16'((`HCIFC_CLK_HZ + rate / 2) / rate);
  endfunction : baud_div

  // two-flop synchronisers for every pin input
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;
  logic rx_prev_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_reg <= 4'hb;
      pin_sync_reg <= 4'hb;
      rx_prev_reg <= 1'b1;
    end else if (clk_en) begin
      pin_meta_reg <= {core_supply_on, main_supply_ok, uart_cts, uart_rxd};
      pin_sync_reg <= pin_meta_reg;
      rx_prev_reg <= pin_sync_reg[0];
    end
  end
  wire rx_s = pin_sync_reg[0];
  wire cts_s = pin_sync_reg[1];
  wire supplies_up = pin_sync_reg[2] & pin_sync_reg[3];

  // power-up sequencing
  hcifc_pwr_t pwr_reg, pwr_next;
  logic [23:0] pwr_cnt_reg, pwr_cnt_next;
  wire por_done = (pwr_cnt_reg == 24'(T_POR_CYC - 1));
  wire nrdy_done = (pwr_cnt_reg == 24'(T_NRDY_CYC - 1));
  always_comb begin
    pwr_next = pwr_reg;
    pwr_cnt_next = pwr_cnt_reg + 24'h1;
    case (pwr_reg)
      PWR_OFF: begin
        pwr_cnt_next = 24'h0;
        if (supplies_up) pwr_next = PWR_POR;
      end
      PWR_POR: begin
        if (por_done) begin
          pwr_next = PWR_PM;
          pwr_cnt_next = 24'h0;
        end
      end
      PWR_PM: begin
        pwr_next = PWR_RADIO;
        pwr_cnt_next = 24'h0;
      end
      PWR_RADIO: begin
        pwr_next = PWR_NRDY;
        pwr_cnt_next = 24'h0;
      end
      PWR_NRDY: begin
        if (nrdy_done) begin
          pwr_next = PWR_RDY;
          pwr_cnt_next = 24'h0;
        end
      end
      default: begin
        pwr_cnt_next = 24'h0;
      end
    endcase
    // losing either supply restarts the whole sequence
    if (!supplies_up) begin
      pwr_next = PWR_OFF;
      pwr_cnt_next = 24'h0;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_reg <= PWR_OFF;
      pwr_cnt_reg <= 24'h0;
    end else if (clk_en) begin
      pwr_reg <= pwr_next;
      pwr_cnt_reg <= pwr_cnt_next;
    end
  end

  // status outputs registered so they never glitch
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pm_en <= 1'b0;
      radio_en <= 1'b0;
      uart_rdy <= 1'b0;
      uart_rts_n <= 1'b1;
    end else if (clk_en) begin
      pm_en <= (pwr_next != PWR_OFF) && (pwr_next != PWR_POR);
      radio_en <= (pwr_next != PWR_OFF) && (pwr_next != PWR_POR) && (pwr_next != PWR_PM);
      uart_rdy <= (pwr_next == PWR_RDY);
      uart_rts_n <= !(hw_flow_en && (pwr_next == PWR_RDY));
    end
  end

  // rate register: default until ready, then follows the selector while idle
  logic [2:0] baud_reg;
  logic tx_busy_reg;
  logic rx_busy_reg;
  wire [15:0] div = baud_div(baud_reg);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      baud_reg <= `HCIFC_BAUD_DEFAULT;
    end else if (clk_en) begin
      // follows the next power state so the rate drops back on the same edge as uart_rdy
      if (pwr_next != PWR_RDY) baud_reg <= `HCIFC_BAUD_DEFAULT;
      else if (!tx_busy_reg && !rx_busy_reg) baud_reg <= baud_sel;
    end
  end

  // transmitter: cts looked at only when a new byte would start
  logic [9:0] tx_shift_reg;
  logic [3:0] tx_bit_reg;
  logic [15:0] tx_cnt_reg;
  assign tx_ready = clk_en && uart_rdy && !tx_busy_reg && !cts_s;
  wire tx_go = tx_valid && tx_ready;
  wire tx_tick = (tx_cnt_reg == 16'h0);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_busy_reg <= 1'b0;
      tx_shift_reg <= 10'h3ff;
      tx_bit_reg <= `HCIFC_BIT_START;
      tx_cnt_reg <= 16'h0;
      uart_txd <= 1'b1;
    end else if (clk_en) begin
      if (tx_go) begin
        tx_busy_reg <= 1'b1;
        tx_shift_reg <= {1'b1, tx_req.data, 1'b0};
        tx_bit_reg <= `HCIFC_BIT_START;
        tx_cnt_reg <= div - 16'h1;
        uart_txd <= 1'b0;
      end else if (tx_busy_reg) begin
        // a byte in flight runs to its stop bit whatever cts does
        if (!tx_tick) begin
          tx_cnt_reg <= tx_cnt_reg - 16'h1;
        end else if (tx_bit_reg == `HCIFC_BIT_STOP) begin
          tx_busy_reg <= 1'b0;
        end else begin
          tx_cnt_reg <= div - 16'h1;
          tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
          uart_txd <= tx_shift_reg[1];
          tx_bit_reg <= tx_bit_reg + 4'h1;
        end
      end
    end
  end

  // packet length guard; h4 ends on the last flag, h5 on the slip delimiter
  logic [10:0] pkt_cnt_reg;
  wire is_delim = h5_mode && (tx_req.data == `HCIFC_H5_DELIM);
  wire [10:0] pkt_limit = tx_req.acl ? `HCIFC_LEN_ACL : `HCIFC_LEN_CMD;
  wire [10:0] pkt_cnt_inc = (pkt_cnt_reg == 11'h7ff) ? pkt_cnt_reg : pkt_cnt_reg + 11'h1;
  wire pkt_end = is_delim || (!h5_mode && tx_req.last);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pkt_cnt_reg <= 11'h0;
      pkt_len_err <= 1'b0;
    end else if (clk_en) begin
      pkt_len_err <= tx_go && !is_delim && (pkt_cnt_inc > pkt_limit);
      if (tx_go) pkt_cnt_reg <= pkt_end ? 11'h0 : pkt_cnt_inc;
    end
  end

  // receiver: centre sampling from the start edge
  logic [7:0] rx_shift_reg;
  logic [3:0] rx_bit_reg;
  logic [15:0] rx_cnt_reg;
  wire rx_tick = (rx_cnt_reg == 16'h0);
  wire rx_fall = rx_prev_reg && !rx_s;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_busy_reg <= 1'b0;
      rx_shift_reg <= 8'h0;
      rx_bit_reg <= `HCIFC_BIT_START;
      rx_cnt_reg <= 16'h0;
      rx_valid <= 1'b0;
      rx_byte <= '0;
    end else if (clk_en) begin
      rx_valid <= 1'b0;
      if (!rx_busy_reg) begin
        if (rx_fall) begin
          rx_busy_reg <= 1'b1;
          rx_bit_reg <= `HCIFC_BIT_START;
          rx_cnt_reg <= {1'b0, div[15:1]};
        end
      end else if (!rx_tick) begin
        rx_cnt_reg <= rx_cnt_reg - 16'h1;
      end else begin
        rx_cnt_reg <= div - 16'h1;
        rx_bit_reg <= rx_bit_reg + 4'h1;
        if (rx_bit_reg == `HCIFC_BIT_START) begin
          if (rx_s) rx_busy_reg <= 1'b0; // glitch, not a start bit
        end else if (rx_bit_reg == `HCIFC_BIT_STOP) begin
          rx_busy_reg <= 1'b0;
          // bytes arriving before ready are dropped, not buffered
          rx_valid <= (pwr_next == PWR_RDY);
          rx_byte <= '{frame_err: !rx_s, data: rx_shift_reg};
        end else begin
          rx_shift_reg <= {rx_s, rx_shift_reg[7:1]};
        end
      end
    end
  end

  // a byte may only start while cts is low
  property p_tx_start_cts;
    @(posedge mclk) disable iff (!rst_n) (!tx_busy_reg && cts_s) |=> !tx_busy_reg;
  endproperty
  a_tx_start_cts: assert property (p_tx_start_cts) else $error("byte started with cts high");

  // the start bit appears on the pin right after a start
  property p_tx_start_bit;
    @(posedge mclk) disable iff (!rst_n) (tx_go && clk_en) |=> (!uart_txd && tx_busy_reg);
  endproperty
  a_tx_start_bit: assert property (p_tx_start_bit) else $error("start bit missing");

  // cts rising mid byte does not cut the byte short
  property p_tx_finish;
    @(posedge mclk) disable iff (!rst_n)
      (tx_busy_reg && clk_en && cts_s && tx_bit_reg != `HCIFC_BIT_STOP) |=> tx_busy_reg;
  endproperty
  a_tx_finish: assert property (p_tx_finish) else $error("byte aborted by cts");

  // no received byte is passed on before ready
  property p_rx_ignored;
    @(posedge mclk) disable iff (!rst_n) rx_valid |-> uart_rdy;
  endproperty
  a_rx_ignored: assert property (p_rx_ignored) else $error("byte delivered while not ready");

  // rate stays at default until ready
  property p_baud_default;
    @(posedge mclk) disable iff (!rst_n) !uart_rdy |-> (baud_reg == `HCIFC_BAUD_DEFAULT);
  endproperty
  a_baud_default: assert property (p_baud_default) else $error("rate changed before ready");

  // manager before radio, radio before ready
  property p_order;
    @(posedge mclk) disable iff (!rst_n) (uart_rdy |-> radio_en) and (radio_en |-> pm_en);
  endproperty
  a_order: assert property (p_order) else $error("power-up order broken");

  // checker-only ages, kept apart from the sequencer so the timing checks are independent
  logic [23:0] sup_age_reg;
  logic [23:0] radio_age_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sup_age_reg <= 24'h0;
      radio_age_reg <= 24'h0;
    end else if (clk_en) begin
      sup_age_reg <= !supplies_up ? 24'h0 : ((&sup_age_reg) ? sup_age_reg : sup_age_reg + 24'h1);
      radio_age_reg <= !radio_en ? 24'h0 : ((&radio_age_reg) ? radio_age_reg : radio_age_reg + 24'h1);
    end
  end

  // ready only rises after the radio has been enabled for the full not-ready count
  property p_nrdy_len;
    @(posedge mclk) disable iff (!rst_n) $rose(uart_rdy) |-> (radio_age_reg > 24'(T_NRDY_CYC));
  endproperty
  a_nrdy_len: assert property (p_nrdy_len) else $error("not-ready interval cut short");

  // reset release waits for the full delay with supplies up
  property p_por_len;
    @(posedge mclk) disable iff (!rst_n) $rose(pm_en) |-> (sup_age_reg > 24'(T_POR_CYC));
  endproperty
  a_por_len: assert property (p_por_len) else $error("internal reset released early");

  // ready indication follows readiness when flow control is on
  property p_rts;
    @(posedge mclk) disable iff (!rst_n) (!uart_rts_n) |-> (uart_rdy && $past(hw_flow_en));
  endproperty
  a_rts: assert property (p_rts) else $error("ready indication early");
endmodule : hcifc_top

// ### hcifc_host.sv
// behavioural host at the far side of the hci serial port
`timescale 1ns/10ps
module hcifc_host (
  // clock
  input wire logic mclk,
  // serial pins
  input wire logic uart_txd,
  output logic uart_rxd,
  output logic uart_cts
);
  // cycles per bit, set by the bench to follow the device rate
  int div = 2170;
  logic [7:0] got_q[$];
  // rx line idles high and cts starts permitting, as a real host does
  initial begin
    uart_rxd = 1'b1;
    uart_cts = 1'b0;
  end
  // decode device transmit line at mid bit; bad stop bit drops the byte
  always begin : rx_loop
    logic [7:0] b;
    @(negedge uart_txd);
    repeat (div / 2) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(posedge mclk);
      b[i] = uart_txd;
    end
    repeat (div) @(posedge mclk);
    if (uart_txd === 1'b1) got_q.push_back(b);
  end
  // one 8n1 character, lsb first, each bit exactly div cycles
  task automatic send_byte(input logic [7:0] b, input logic stop_bit);
    logic [9:0] f;
    f = {stop_bit, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk);
      uart_rxd <= f[i];
      repeat (div - 1) @(posedge mclk);
    end
    @(posedge mclk);
    uart_rxd <= 1'b1;
  endtask : send_byte
  // stop request; never shorter than one byte time
  task automatic hold_cts(input int n);
    int len;
    len = (n > 10 * div + 1) ? n : 10 * div + 1;
    @(posedge mclk);
    uart_cts <= 1'b1;
    repeat (len) @(posedge mclk);
    uart_cts <= 1'b0;
  endtask : hold_cts
endmodule : hcifc_host

// ### hcifc_top_bench.sv
// self-checking bench for the hci serial port
`timescale 1ns/10ps
module hcifc_top_bench;
  import hcifc_pkg::*;
  logic mclk = 1'b0;
  logic rst_n, clk_en, main_supply_ok, core_supply_on, hw_flow_en, h5_mode, tx_valid;
  logic [2:0] baud_sel;
  hcifc_tx_t tx_req;
  logic uart_rxd, uart_cts, uart_txd, uart_rts_n, pm_en, radio_en, uart_rdy, tx_ready, pkt_len_err, rx_valid;
  hcifc_rx_t rx_byte, rx_last;
  int n_mismatch = 0;
  int tests_run = 0;
  int rx_cnt = 0;
  int n_len_err = 0;
  always #2 mclk = ~mclk;
  // short power-up counts keep the run small; not-ready outlasts one slow byte
  hcifc_top #(.T_POR_CYC(20), .T_NRDY_CYC(25000)) i_hcifc_top (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
    .main_supply_ok(main_supply_ok), .core_supply_on(core_supply_on), .baud_sel(baud_sel),
    .hw_flow_en(hw_flow_en), .h5_mode(h5_mode), .uart_rxd(uart_rxd), .uart_cts(uart_cts),
    .uart_txd(uart_txd), .uart_rts_n(uart_rts_n), .pm_en(pm_en), .radio_en(radio_en), .uart_rdy(uart_rdy),
    .tx_valid(tx_valid), .tx_req(tx_req), .tx_ready(tx_ready), .pkt_len_err(pkt_len_err),
    .rx_valid(rx_valid), .rx_byte(rx_byte));
  hcifc_host i_hcifc_host (.mclk(mclk), .uart_txd(uart_txd), .uart_rxd(uart_rxd), .uart_cts(uart_cts));
  // count received bytes and keep the last one
  always @(posedge mclk) if (rx_valid === 1'b1) begin
    rx_cnt <= rx_cnt + 1;
    rx_last <= rx_byte;
  end
  // count length error pulses; the bench never sends an over-long packet
  always @(posedge mclk) if (pkt_len_err === 1'b1) n_len_err <= n_len_err + 1;
  task automatic print_verdict();
    if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // bounded wait for a level; running out ends the run
  task automatic wait_hi(ref logic s, input int lim, output int n);
    n = 0;
    while (s !== 1'b1) begin
      @(posedge mclk);
      n++;
      if (n > lim) begin
        n_mismatch++;
        print_verdict();
      end
    end
  endtask : wait_hi
  task automatic wait_got(input int k);
    int n;
    n = 0;
    while (i_hcifc_host.got_q.size() < k) begin
      @(posedge mclk);
      n++;
      if (n > 30000) begin
        n_mismatch++;
        print_verdict();
      end
    end
  endtask : wait_got
  // offer one byte and hold it until the edge that takes it
  task automatic tx_send(input logic [7:0] b);
    int n;
    n = 0;
    @(posedge mclk);
    tx_valid <= 1'b1;
    tx_req <= {1'b0, 1'b0, b};
    // tx_ready read right at an edge is the value the design took the byte on
    do begin
      @(posedge mclk);
      n++;
      if (n > 30000) begin
        n_mismatch++;
        print_verdict();
      end
    end while (tx_ready !== 1'b1);
    tx_valid <= 1'b0;
  endtask : tx_send
  // pre-charge, cut, formal power-up; dropped rx byte while not ready
  task automatic t_power();
    int n, c;
    @(posedge mclk);
    main_supply_ok <= 1'b1;
    repeat (10) @(posedge mclk);
    main_supply_ok <= 1'b0;
    repeat (100) @(posedge mclk);
    main_supply_ok <= 1'b1;
    core_supply_on <= 1'b1;
    wait_hi(pm_en, 200, n);
    check(n >= 20 && n <= 30, 1);
    check({radio_en, uart_rdy, uart_rts_n}, 3'b001);
    wait_hi(radio_en, 5, n);
    check(uart_rdy, 1'b0);
    c = rx_cnt;
    i_hcifc_host.send_byte(8'h5a, 1'b1);
    repeat (20) @(posedge mclk);
    check(rx_cnt - c, 0);
    check({uart_rdy, uart_rts_n}, 2'b01);
    wait_hi(uart_rdy, 5000, n);
    @(posedge mclk);
    check(uart_rts_n, 1'b0);
  endtask : t_power
  // default rate: start bit of a byte with d0 set lasts one bit time
  task automatic t_tx_slow();
    int n;
    tx_send(8'h01);
    n = 0;
    while (uart_txd !== 1'b0 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    n = 0;
    while (uart_txd === 1'b0 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    check(n >= 2105 && n <= 2235, 1);
    wait_got(1);
    check(i_hcifc_host.got_q.pop_front(), 8'h01);
    wait_hi(tx_ready, 30000, n);
  endtask : t_tx_slow
  // top rate, bytes back to back
  task automatic t_burst();
    logic [7:0] d[4] = '{8'h3c, 8'hc3, 8'h81, 8'hc0};
    @(posedge mclk);
    baud_sel <= 3'h7;
    h5_mode <= 1'b1;
    i_hcifc_host.div = 83;
    foreach (d[i]) tx_send(d[i]);
    wait_got(4);
    foreach (d[i]) check(i_hcifc_host.got_q.pop_front(), d[i]);
  endtask : t_burst
  // stop mid byte: that byte completes, the next waits for cts low
  task automatic t_cts();
    tx_send(8'h96);
    repeat (250) @(posedge mclk);
    fork
      i_hcifc_host.hold_cts(1500);
    join_none
    tx_send(8'h69);
    check(uart_cts, 1'b0);
    check(i_hcifc_host.got_q.size(), 1);
    wait_got(2);
    check(i_hcifc_host.got_q.pop_front(), 8'h96);
    check(i_hcifc_host.got_q.pop_front(), 8'h69);
  endtask : t_cts
  // receive a good byte, then one with a low stop bit
  task automatic t_rx();
    int c;
    c = rx_cnt;
    i_hcifc_host.send_byte(8'h4b, 1'b1);
    repeat (20) @(posedge mclk);
    check(rx_cnt - c, 1);
    check(rx_last, {1'b0, 8'h4b});
    i_hcifc_host.send_byte(8'hb4, 1'b0);
    repeat (20) @(posedge mclk);
    check(rx_last, {1'b1, 8'hb4});
    check(n_len_err, 0);
    // flow control off: ready indication goes back to inactive
    @(posedge mclk);
    hw_flow_en <= 1'b0;
    repeat (2) @(posedge mclk);
    check(uart_rts_n, 1'b1);
  endtask : t_rx
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    hw_flow_en = 1'b1;
    h5_mode = 1'b0;
    main_supply_ok = 1'b0;
    core_supply_on = 1'b0;
    baud_sel = 3'h0;
    tx_valid = 1'b0;
    tx_req = '0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    t_power();
    t_tx_slow();
    t_burst();
    t_cts();
    t_rx();
    print_verdict();
  end
endmodule : hcifc_top_bench
